// >>> hw/brake_seq_regs.svh
// register offsets, field positions, reset values and timing constants
`ifndef BRAKE_SEQ_REGS_SVH
`define BRAKE_SEQ_REGS_SVH

// =====================================================================
// register byte offsets
`define REG_CTRL 8'h00
`define REG_DELAY 8'h04
`define REG_STOPTIME 8'h08
`define REG_SPDLIM 8'h0C
`define REG_RESTART 8'h10
`define REG_COAST 8'h14
`define REG_STATUS 8'h18
`define REG_COUNT 4'h6
`define IDX_NONE 4'hF

// =====================================================================
// control field positions
`define CTRL_USAGE 0
`define CTRL_ACKAUTO 1
`define CTRL_ESTOP_RAMP 2
`define CTRL_FB_NC 3
`define CTRL_DIAG_A 4
`define CTRL_DIAG_B 5
`define CTRL_OUT_PAIR 6
`define CTRL_FBACT 8
`define CTRL_ACK_WR 15
`define CTRL_RD_MASK 16'h03FF

`define FBACT_TORQUE 2'h1
`define FBACT_SAFE 2'h2

// =====================================================================
// reset values
`define CTRL_RST 16'h0002
`define DELAY_RST 16'h0000
`define STOPTIME_RST 16'h04B0
`define SPDLIM_RST 16'h0000
`define RESTART_RST 16'h03E8
`define COAST_RST 16'h05DC

// =====================================================================
// timing
`define CLK_PERIOD_NS 20
`define MS_NS 1000000
`define CYC_PER_MS (`MS_NS / `CLK_PERIOD_NS)
`define FB_CHECK_MS 16'h0014
`define TEST_PULSE_MS 8'h0A

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// >>> hw/brake_seq_pkg.sv
// types shared by the brake and torque-off sequencer
package brake_seq_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_RAMP,
    ST_BRAKE_LEAD,
    ST_TORQUE_LAG,
    ST_HOLD
  } seq_state_e;

  // synchronised request and feedback inputs
  typedef struct packed {
    logic relayFeedback;
    logic zeroSpeed;
    logic internalFault;
    logic monitorLimitHit;
    logic tripLimitHit;
    logic emergencyStopReq;
    logic controlledStopReq;
    logic torqueOffReq;
  } req_s;

  typedef struct packed {
    logic brakeUsage;
    logic ackAuto;
    logic estopRamp;
    logic fbNc;
    logic diagA;
    logic diagB;
    logic outPair;
    logic [1:0] fbAction;
    logic [15:0] brakeDelay;
    logic [15:0] brakeStopTime;
    logic [15:0] speedLimit;
    logic [15:0] restartDelay;
    logic [15:0] coastStopTime;
  } cfg_s;

endpackage

// >>> hw/ms_timebase.sv
// millisecond tick and diagnostic test pulse strobe
`timescale 1ns/1ps
`include "brake_seq_regs.svh"

module ms_timebase #(
  parameter int CYC_PER_MS = `CYC_PER_MS
) (
  input logic clk_sys,
  input logic resetn,
  output logic msTick,
  output logic testPulse
);

  logic [31:0] cyc_q;
  logic [7:0] msCnt_q;
  logic wrap;

  assign wrap = (cyc_q == 32'(CYC_PER_MS - 1));
  assign msTick = wrap;
  assign testPulse = wrap && (msCnt_q == 8'h00);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cyc_q <= 32'h0;
      msCnt_q <= 8'h00;
    end else if (wrap) begin
      cyc_q <= 32'h0;
      msCnt_q <= (msCnt_q == `TEST_PULSE_MS - 8'h01) ? 8'h00
                 : msCnt_q + 8'h01;
    end else begin
      cyc_q <= cyc_q + 32'h1;
    end
  end

endmodule

// >>> hw/brake_torque_off_sequencer.sv
// sequencer coordinating safe brake outputs with drive torque off
`timescale 1ns/1ps
`include "brake_seq_regs.svh"
// =====================================================================

module brake_torque_off_sequencer #(
  parameter int CYC_PER_MS = `CYC_PER_MS
) (
  input logic clk_sys,
  input logic resetn,
  input logic torqueOffReqPin,
  input logic controlledStopReqPin,
  input logic emergencyStopReqPin,
  input logic tripLimitHitPin,
  input logic monitorLimitHitPin,
  input logic internalFaultPin,
  input logic zeroSpeedPin,
  input logic relayFeedbackPin,
  input logic [15:0] speedRpm,
  output logic torqueOff,
  output logic brakeOutA,
  output logic brakeOutB,
  output logic stopCompleted,
  output logic restartPermit,
  output logic ackPulse,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready
);

  // ===================================================================
  // helpers
  function automatic logic [3:0] regIdx(input logic [7:0] a);
    regIdx = (a[1:0] == 2'h0 && a[7:2] <= 6'h06) ? a[5:2] : `IDX_NONE;
  endfunction

  function automatic logic [15:0] absMag(input logic [15:0] v);
    absMag = v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [15:0] satInc(input logic [15:0] v,
                                         input logic t);
    satInc = (t && v != 16'hFFFF) ? v + 16'h0001 : v;
  endfunction

  function automatic logic [15:0] rstVal(input logic [3:0] i);
    case (i)
      4'h0: rstVal = `CTRL_RST;
      4'h1: rstVal = `DELAY_RST;
      4'h2: rstVal = `STOPTIME_RST;
      4'h3: rstVal = `SPDLIM_RST;
      4'h4: rstVal = `RESTART_RST;
      default: rstVal = `COAST_RST;
    endcase
  endfunction

  // ===================================================================
  // declarations
  logic msTick, testPulse;
  logic [7:0] pinVec, syncA_q, syncB_q;
  brake_seq_pkg::req_s req;
  brake_seq_pkg::cfg_s cfg;
  logic [15:0] cfgMem_q [0:5];
  brake_seq_pkg::seq_state_e state_q, state_d, entryNext;
  logic brakeOn_q, brakeOn_d, torqueOff_q, torqueOff_d;
  logic [15:0] stateTimer_q, stopTimer_q, restartTimer_q, fbTimer_q;
  logic [15:0] delayMag, speedMag, expectTime;
  logic torqueBrakeEn, rampBrakeEn, delayNeg, delayZero, delayPos;
  logic estopAny, forceSafe, immStop, rampStop, anyReq, atBrakeSpeed;
  logic brakeSel, entryLead, entryLag, delayDone, ackGo, ackWr;
  logic restartOk, relayOn, fbExpect, fbMismatch, fbHit, timeoutHit;
  logic feedbackFault_q, stopTimeout_q, stopDone_q, ackPulse_q;
  logic brakeOutA_q, brakeOutB_q, restartOk_q;
  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q, doWrite;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q, rdata_q, rdMux;
  logic [3:0] wStrb_q, wIdx, rIdx;
  logic [1:0] bresp_q, rresp_q;
  logic [15:0] statusWord;

  ms_timebase #(.CYC_PER_MS(CYC_PER_MS)) u_timebase (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .msTick(msTick),
    .testPulse(testPulse)
  );

  // ===================================================================
  // input synchronisers
  assign pinVec = {relayFeedbackPin, zeroSpeedPin, internalFaultPin,
                   monitorLimitHitPin, tripLimitHitPin,
                   emergencyStopReqPin, controlledStopReqPin,
                   torqueOffReqPin};

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      syncA_q <= 8'h00;
      syncB_q <= 8'h00;
    end else begin
      syncA_q <= pinVec;
      syncB_q <= syncA_q;
    end
  end

  assign req = brake_seq_pkg::req_s'(syncB_q);

  // ===================================================================
  // configuration view
  assign cfg.brakeUsage = cfgMem_q[0][`CTRL_USAGE];
  assign cfg.ackAuto = cfgMem_q[0][`CTRL_ACKAUTO];
  assign cfg.estopRamp = cfgMem_q[0][`CTRL_ESTOP_RAMP];
  assign cfg.fbNc = cfgMem_q[0][`CTRL_FB_NC];
  assign cfg.diagA = cfgMem_q[0][`CTRL_DIAG_A];
  assign cfg.diagB = cfgMem_q[0][`CTRL_DIAG_B];
  assign cfg.outPair = cfgMem_q[0][`CTRL_OUT_PAIR];
  assign cfg.fbAction = cfgMem_q[0][`CTRL_FBACT +: 2];
  assign cfg.brakeDelay = cfgMem_q[1];
  assign cfg.brakeStopTime = cfgMem_q[2];
  assign cfg.speedLimit = cfgMem_q[3];
  assign cfg.restartDelay = cfgMem_q[4];
  assign cfg.coastStopTime = cfgMem_q[5];

  // ===================================================================
  // stop request decode
  assign torqueBrakeEn = cfg.brakeUsage;
  assign rampBrakeEn = (cfg.speedLimit != 16'h0000);
  assign delayMag = absMag(cfg.brakeDelay);
  assign delayNeg = cfg.brakeDelay[15];
  assign delayZero = (cfg.brakeDelay == 16'h0000);
  assign delayPos = !delayNeg && !delayZero;
  assign speedMag = absMag(speedRpm);
  // same limit both directions
  assign atBrakeSpeed = rampBrakeEn && speedMag <= cfg.speedLimit;
  assign estopAny = req.emergencyStopReq || req.tripLimitHit;
  assign forceSafe = req.internalFault || stopTimeout_q ||
                     (feedbackFault_q && cfg.fbAction == `FBACT_SAFE);
  assign immStop = req.torqueOffReq || req.monitorLimitHit ||
                   (feedbackFault_q && cfg.fbAction == `FBACT_TORQUE) ||
                   forceSafe || (estopAny && !cfg.estopRamp);
  assign rampStop = req.controlledStopReq ||
                    (estopAny && cfg.estopRamp);
  assign anyReq = immStop || rampStop;

  // forced-safe faults brake whenever any brake path is configured, unless the sequencer is already in ST_HOLD
  assign brakeSel = forceSafe ? (torqueBrakeEn || rampBrakeEn)
                              : torqueBrakeEn;
  assign entryLead = brakeSel && delayNeg && !forceSafe;
  assign entryLag = brakeSel && delayPos && !forceSafe;
  assign entryNext = entryLead ? brake_seq_pkg::ST_BRAKE_LEAD
                   : entryLag ? brake_seq_pkg::ST_TORQUE_LAG
                   : brake_seq_pkg::ST_HOLD;
  // one tick past the delay: only a forced-safe fault ends a wait short of it
  assign delayDone = msTick && stateTimer_q >= delayMag;
  assign restartOk = restartTimer_q > cfg.restartDelay;
  assign ackGo = !anyReq && restartOk &&
                 (cfg.ackAuto ? stopDone_q : ackWr);

  // ===================================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    brakeOn_d = brakeOn_q;
    torqueOff_d = torqueOff_q;
    case (state_q)
      brake_seq_pkg::ST_RUN, brake_seq_pkg::ST_RAMP: begin
        if (immStop || (state_q == brake_seq_pkg::ST_RAMP &&
                        req.zeroSpeed && !atBrakeSpeed)) begin
          state_d = entryNext;
          brakeOn_d = brakeSel && !entryLag;
          torqueOff_d = !entryLead;
        end else if (state_q == brake_seq_pkg::ST_RAMP &&
                     atBrakeSpeed) begin
          state_d = delayNeg ? brake_seq_pkg::ST_BRAKE_LEAD
                             : brake_seq_pkg::ST_HOLD;
          brakeOn_d = 1'b1;
          torqueOff_d = !delayNeg;
        end else if (rampStop) begin
          state_d = brake_seq_pkg::ST_RAMP;
        end
      end
      brake_seq_pkg::ST_BRAKE_LEAD: begin
        if (forceSafe || delayDone) begin
          state_d = brake_seq_pkg::ST_HOLD;
          torqueOff_d = 1'b1;
        end
      end
      brake_seq_pkg::ST_TORQUE_LAG: begin
        if (forceSafe || delayDone) begin
          state_d = brake_seq_pkg::ST_HOLD;
          brakeOn_d = 1'b1;
        end
      end
      brake_seq_pkg::ST_HOLD: begin
        if (ackGo) begin
          state_d = brake_seq_pkg::ST_RUN;
          brakeOn_d = 1'b0;
          torqueOff_d = 1'b0;
        end
      end
      default: begin
        state_d = brake_seq_pkg::ST_HOLD;
        torqueOff_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= brake_seq_pkg::ST_RUN;
      brakeOn_q <= 1'b0;
      torqueOff_q <= 1'b0;
    end else begin
      state_q <= state_d;
      brakeOn_q <= brakeOn_d;
      torqueOff_q <= torqueOff_d;
    end
  end

  // ===================================================================
  // millisecond timers
  assign expectTime = brakeOn_q ? cfg.brakeStopTime
                                : cfg.coastStopTime;
  // motor still turning after coast time: brake did not hold
  assign timeoutHit = state_q != brake_seq_pkg::ST_RUN &&
                      !req.zeroSpeed &&
                      stopTimer_q > cfg.coastStopTime;
  assign relayOn = !brakeOn_q;
  assign fbExpect = cfg.fbNc ? !relayOn : relayOn;
  assign fbMismatch = req.relayFeedback != fbExpect;
  assign fbHit = fbTimer_q > `FB_CHECK_MS;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stateTimer_q <= 16'h0000;
      stopTimer_q <= 16'h0000;
      restartTimer_q <= 16'h0000;
      fbTimer_q <= 16'h0000;
    end else begin
      stateTimer_q <= (state_d != state_q) ? 16'h0000
                      : satInc(stateTimer_q, msTick);
      stopTimer_q <= (state_q == brake_seq_pkg::ST_RUN) ? 16'h0000
                     : satInc(stopTimer_q, msTick);
      restartTimer_q <= !torqueOff_q ? 16'h0000
                        : satInc(restartTimer_q, msTick);
      fbTimer_q <= !fbMismatch ? 16'h0000
                   : satInc(fbTimer_q, msTick);
    end
  end

  // sticky faults; a new hit outweighs the clearing write
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      feedbackFault_q <= 1'b0;
      stopTimeout_q <= 1'b0;
      stopDone_q <= 1'b0;
      ackPulse_q <= 1'b0;
      restartOk_q <= 1'b0;
    end else begin
      feedbackFault_q <= fbHit || (feedbackFault_q && !ackWr);
      stopTimeout_q <= timeoutHit || (stopTimeout_q && !ackWr);
      stopDone_q <= state_q == brake_seq_pkg::ST_HOLD &&
                    (req.zeroSpeed || stopTimer_q >= expectTime);
      ackPulse_q <= state_q == brake_seq_pkg::ST_HOLD && ackGo;
      restartOk_q <= restartOk && torqueOff_q;
    end
  end

  // ===================================================================
  // brake outputs: energised relay releases the brake
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      brakeOutA_q <= 1'b0;
      brakeOutB_q <= 1'b0;
    end else begin
      brakeOutA_q <= relayOn && !(cfg.diagA && testPulse);
      brakeOutB_q <= cfg.outPair && relayOn &&
                     !(cfg.diagB && testPulse);
    end
  end

  assign torqueOff = torqueOff_q;
  assign brakeOutA = brakeOutA_q;
  assign brakeOutB = brakeOutB_q;
  assign stopCompleted = stopDone_q;
  assign restartPermit = restartOk_q;
  assign ackPulse = ackPulse_q;

  // ===================================================================
  // register bus
  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign wIdx = regIdx(awAddr_q);
  assign rIdx = regIdx(s_axi_araddr);
  assign ackWr = doWrite && wIdx == 4'h0 && wStrb_q[1] &&
                 wData_q[`CTRL_ACK_WR];
  assign statusWord = {5'h00, 3'(state_q), 1'b0, fbMismatch,
                       stopTimeout_q, feedbackFault_q, restartOk,
                       stopDone_q, brakeOn_q, torqueOff_q};
  assign rdMux = (rIdx == 4'h6) ? {16'h0000, statusWord}
               : (rIdx == 4'h0) ? {16'h0000, cfgMem_q[0] & `CTRL_RD_MASK}
               : (rIdx < `REG_COUNT) ? {16'h0000, cfgMem_q[3'(rIdx)]}
               : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wIdx == `IDX_NONE) ? `RESP_DECERR : `RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // status is read only; writes to it are accepted and dropped
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < 6; i++) begin
        cfgMem_q[i] <= rstVal(4'(i));
      end
    end else if (doWrite && wIdx < `REG_COUNT) begin
      for (int b = 0; b < 2; b++) begin
        if (wStrb_q[b]) begin
          cfgMem_q[3'(wIdx)][8*b +: 8] <= wData_q[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= (rIdx == `IDX_NONE) ? `RESP_DECERR : `RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ===================================================================
  // assertions
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_ack_go;
    state_q == brake_seq_pkg::ST_HOLD && ackGo;
  endsequence

  sequence s_released;
    state_q == brake_seq_pkg::ST_RUN && !brakeOn_q && !torqueOff_q;
  endsequence

  a_auto_release: assert property (
    s_ack_go |=> s_released)
    else $error("hold exit did not release brake and torque");
  a_lead_order: assert property (
    state_q == brake_seq_pkg::ST_BRAKE_LEAD |-> brakeOn_q && !torqueOff_q)
    else $error("brake lead without brake only");
  a_lag_order: assert property (
    state_q == brake_seq_pkg::ST_TORQUE_LAG |-> torqueOff_q && !brakeOn_q)
    else $error("torque lag without torque off only");
  a_zero_together: assert property (
    $rose(torqueOff_q) && $past(torqueBrakeEn && delayZero) |-> brakeOn_q)
    else $error("zero delay did not brake with torque off");
  a_brake_needs_cfg: assert property (
    $rose(brakeOn_q) |-> $past(torqueBrakeEn || rampBrakeEn))
    else $error("brake engaged with no brake path configured");
  a_fault_torque: assert property (
    forceSafe |=> torqueOff_q)
    else $error("forced safe state without torque off");
  a_restart_wait: assert property (
    $fell(torqueOff_q) |-> $past(restartOk))
    else $error("torque restored before restart delay");
  a_fb_fault: assert property (
    fbHit |=> feedbackFault_q)
    else $error("feedback mismatch not flagged");
  a_timeout_safe: assert property (
    timeoutHit |=> stopTimeout_q ##1 torqueOff_q)
    else $error("stop timeout did not force torque off");
  a_pair_outputs: assert property (
    cfg.outPair && !cfg.diagA && !cfg.diagB |=> brakeOutA_q == brakeOutB_q)
    else $error("redundant brake outputs disagree");
  a_trip_stop: assert property (
    req.tripLimitHit && !cfg.estopRamp &&
    state_q == brake_seq_pkg::ST_RUN |=> torqueOff_q || brakeOn_q)
    else $error("trip hit did not start emergency stop");

endmodule

// >>> testbench/brake_relay_model.sv
// brake relay with mechanically linked normally-closed contacts
`timescale 1ns/1ps
module brake_relay_model (
  input wire logic clk_sys,
  input wire logic coilOn,
  input wire logic stuck,
  output logic contactFb
);
  initial contactFb = 1'b1;
  // =====================================================
  // contact lags the coil one cycle; stuck welds it wrong
  always @(posedge clk_sys) begin
    contactFb <= stuck ? coilOn : ~coilOn;
  end
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the brake and torque-off sequencer
`timescale 1ns/1ps
`include "brake_seq_regs.svh"
module testbench;
  localparam int CPM = 50;
  localparam int RMS = 2;
  localparam int SLIM = 1500;
  logic clk_sys, resetn, tOffReq, cStop, eStop, trip, mon, fault, zero;
  logic fb, stuck, torqueOff, brakeOutA, brakeOutB, stopDone, restartPermit;
  logic ackPulse, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [15:0] speedRpm;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int err_count, total_checks, i, n;
  logic [7:0] ads[7] = '{`REG_CTRL, `REG_DELAY, `REG_STOPTIME, `REG_SPDLIM,
    `REG_RESTART, `REG_COAST, 8'h1C};
  logic [31:0] exps[7] = '{`CTRL_RST, `DELAY_RST, `STOPTIME_RST,
    `SPDLIM_RST, `RESTART_RST, `COAST_RST, 32'h0};

  brake_torque_off_sequencer #(.CYC_PER_MS(CPM)) uut (
    .clk_sys(clk_sys), .resetn(resetn), .torqueOffReqPin(tOffReq),
    .controlledStopReqPin(cStop), .emergencyStopReqPin(eStop),
    .tripLimitHitPin(trip), .monitorLimitHitPin(mon),
    .internalFaultPin(fault), .zeroSpeedPin(zero), .relayFeedbackPin(fb),
    .speedRpm(speedRpm), .torqueOff(torqueOff), .brakeOutA(brakeOutA),
    .brakeOutB(brakeOutB), .stopCompleted(stopDone),
    .restartPermit(restartPermit), .ackPulse(ackPulse),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  brake_relay_model relay (.clk_sys(clk_sys), .coilOn(brakeOutA),
    .stuck(stuck), .contactFb(fb));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // =====================================================
  // checking and bus tasks
  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic eq(input logic [31:0] g, input logic [31:0] e,
    input string m);
    chk(g === e, m);
  endtask
  // window of a whole-ms wait, a few cycles of pipeline slack
  function automatic bit inWin(int c, int ms);
    return c >= ms * CPM - 3 && c <= (ms + 1) * CPM + 3;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] e);
    int k;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    eq({k < 50, bresp}, {1'b1, e}, "write response");
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    v = rdata;
    r = rresp;
    chk(k < 50, "read hang");
  endtask
  task automatic doReset();
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask
  // one stop request, measured, then withdrawn under auto acknowledge
  task automatic runSeq(input int d, input int src);
    int tT, tB, tR, k, s;
    bit tog;
    wr(`REG_DELAY, {16'h0000, d[15:0]}, 4'h3, `RESP_OKAY);
    // ramp stop inside the speed limit ignores a positive delay
    s = $signed(speedRpm);
    tog = d == 0 || (src == 4 && d > 0 && (s < 0 ? -s : s) <= SLIM);
    @(posedge clk_sys);
    case (src)
      0: tOffReq <= 1'b1;
      1: eStop <= 1'b1;
      2: mon <= 1'b1;
      3: trip <= 1'b1;
      default: cStop <= 1'b1;
    endcase
    tT = -1;
    tB = -1;
    tR = -1;
    for (k = 0; k < 2000 && (tB < 0 || tR < 0); k++) begin
      @(posedge clk_sys);
      if (tT < 0 && torqueOff === 1'b1) tT = k;
      if (tB < 0 && brakeOutA === 1'b0) tB = k;
      if (tR < 0 && restartPermit === 1'b1) tR = k;
    end
    if (tog) chk(tT >= 0 && tB >= 0 && tT - tB <= 2 && tB - tT <= 2,
      "brake and torque apart");
    else chk(tB >= 0 && tT >= 0 && inWin(d < 0 ? tT - tB : tB - tT,
      d < 0 ? -d : d), "brake delay");
    chk(tR >= 0 && inWin(tR - tT, RMS), "restart delay");
    eq(stopDone, 1'b1, "stop not completed");
    {tOffReq, eStop, mon, trip, cStop} <= '0;
    for (k = 0; k < 500 && ackPulse !== 1'b1; k++) @(posedge clk_sys);
    chk(k < 500, "no acknowledge");
    repeat (2) @(posedge clk_sys);
    eq({torqueOff, brakeOutA, brakeOutB}, 3'b011, "no release");
  endtask

  // =====================================================
  // main sequence
  initial begin
    {tOffReq, cStop, eStop, trip, mon, fault, stuck} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, speedRpm} = '0;
    zero = 1'b1;
    resetn = 1'b0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(64));
    doReset();
    for (i = 0; i < 7; i++) begin
      rd(ads[i]);
      eq(v, exps[i], "reset value");
      eq(r, i == 6 ? `RESP_DECERR : `RESP_OKAY, "reset resp");
    end
    wr(8'h1C, 32'h0, 4'hF, `RESP_DECERR);
    wr(`REG_COAST, 32'h0000ABCD, 4'h1, `RESP_OKAY);
    rd(`REG_COAST);
    eq(v, 32'h000005CD, "strobe");
    wr(`REG_CTRL, 32'h0000014B, 4'h3, `RESP_OKAY);
    wr(`REG_RESTART, RMS, 4'hF, `RESP_OKAY);
    runSeq(0, 1'b0);
    runSeq(-3, 1'b1);
    runSeq(2, 2);
    runSeq(-1, 3);
    wr(`REG_SPDLIM, SLIM, 4'h3, `RESP_OKAY);
    speedRpm <= 16'hFF9C;
    runSeq(-2, 4);
    runSeq(3, 4);
    for (i = 0; i < 6; i++) begin
      speedRpm <= 16'($urandom_range(6000) - 3000);
      runSeq(int'($urandom_range(8)) - 4, int'($urandom_range(4)));
    end
    wr(`REG_CTRL, 32'h0000017B, 4'h3, `RESP_OKAY);
    n = 0;
    repeat (1000) begin
      @(posedge clk_sys);
      n += (brakeOutA === 1'b0) + (brakeOutB === 1'b0);
    end
    eq(n, 4, "test pulses");
    // pulses would keep resetting the feedback timer in the stuck test
    wr(`REG_CTRL, 32'h0000014B, 4'h3, `RESP_OKAY);
    stuck <= 1'b1;
    for (n = 0; n < 1500 && torqueOff !== 1'b1; n++) @(posedge clk_sys);
    chk(n > 900 && n < 1500, "feedback reaction");
    stuck <= 1'b0;
    doReset();
    @(posedge clk_sys);
    fault <= 1'b1;
    for (n = 0; n < 20 && torqueOff !== 1'b1; n++) @(posedge clk_sys);
    chk(n < 20, "fault torque off");
    repeat (60) @(posedge clk_sys);
    eq(brakeOutA, 1'b1, "unconfigured brake");
    wr(`REG_COAST, 32'h0000_0005, 4'h3, `RESP_OKAY);
    zero <= 1'b0;
    repeat (400) @(posedge clk_sys);
    rd(8'h18);
    eq(v[5], 1'b1, "stop timeout");
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end
endmodule
